// >>> verification/spcd_flash_model.sv
// Purpose: behavioural flash answering the protection command sequences
// Assumes: writes latched on the rising write strobe with chip enable low
// Notes:   read data valid T_ACC after the read strobe falls
`timescale 1ns/100ps
`default_nettype none
module spcd_flash_model #(
	parameter int          T_ACC    = 20,
	parameter logic [15:0] ERR_STAT = 16'h0002
) (
	// bus from the controller
	input  wire logic [25:0] f_addr,
	input  wire logic [15:0] f_dq_o,
	input  wire logic        f_dq_oe,
	input  wire logic        f_ce_n,
	input  wire logic        f_we_n,
	input  wire logic        f_oe_n,
	// read data back
	output logic      [15:0] f_dq_i
);
	typedef enum logic [2:0] {m_arr, m_dyn, m_pers, m_frz, m_err, m_pwd, m_lck} spcd_mode_t;
	spcd_mode_t    mode = m_arr;
	logic [1023:0] dyn_prot = '0;
	logic [1023:0] pers_prot = '0;
	logic          frz = 1'b1, pend = 1'b0, ex = 1'b0, unlocked = 1'b0, drv = 1'b0;
	logic [15:0]   lock_reg = 16'hFFFF, rdat = 16'h0000;
	logic [63:0]   pwd = '0, buf_w = '0;
	logic [3:0]    ucnt = 4'h0;
	logic [7:0]    d;
	logic [9:0]    s;

	// ==========================================================
	// command decode
	always @(posedge f_we_n) if (!f_ce_n) begin
		d = f_dq_o[7:0];
		s = f_addr[25:16];
		if (mode == m_arr) begin
			if (ucnt == 4'h0 && f_addr[10:0] == 11'h555 && d == 8'hAA) ucnt = 4'h1;
			else if (ucnt == 4'h1 && f_addr[10:0] == 11'h2AA && d == 8'h55) ucnt = 4'h2;
			else begin
				if (ucnt == 4'h2 && f_addr[10:0] == 11'h555) begin
					case (d)
						8'hE0: mode = m_dyn;
						8'hC0: mode = m_pers;
						8'h50: mode = m_frz;
						8'h75: mode = m_err;
						8'h60: mode = m_pwd;
						8'h40: mode = m_lck;
						default: mode = m_arr; // no buffer load modelled
					endcase
				end
				// lone suspend or resume writes never match, so they fall away here
				ucnt = 4'h0;
			end
		end else if (ucnt != 4'h0) begin
			if (ucnt >= 4'h5 && ucnt <= 4'h8) buf_w[16*f_addr[1:0] +: 16] = f_dq_o;
			if (ucnt == 4'h9) unlocked = (d == 8'h29) && (buf_w == pwd);
			ucnt = (ucnt == 4'h9) ? 4'h0 : ucnt + 4'h1;
		end else if (pend) begin
			pend = 1'b0;
			case (mode)
				m_dyn: dyn_prot[s] = (d == 8'h00);
				m_pers: pers_prot[s] = 1'b1;
				m_frz: if (d == 8'h00) frz = 1'b0;
				m_lck: begin
					if (f_dq_o[2:1] == 2'b00) mode = m_arr;
					else lock_reg = lock_reg & f_dq_o;
				end
				m_pwd: pwd[16*f_addr[1:0] +: 16] = f_dq_o;
				default: ;
			endcase
		end else if (ex) begin
			ex = 1'b0;
			if (d == 8'h00) mode = m_arr;
		end else if (d == 8'hF0) mode = m_arr;
		else if (d == 8'h90) ex = 1'b1;
		else if (d == 8'hA0) pend = 1'b1;
		else if (mode == m_pwd && d == 8'h25) ucnt = 4'h4;
	end

	// ==========================================================
	// read data, only on the read strobe
	always @(negedge f_oe_n) begin
		drv = 1'b0;
		#(T_ACC);
		case (mode)
			m_arr: rdat = f_addr[15:0] ^ 16'hA5C3;
			m_dyn: rdat = {15'h0000, !dyn_prot[f_addr[25:16]]};
			m_pers: rdat = {15'h0000, !pers_prot[f_addr[25:16]]};
			m_frz: rdat = {15'h0000, frz};
			m_err: rdat = ERR_STAT;
			m_lck: rdat = lock_reg;
			default: rdat = pwd[16*f_addr[1:0] +: 16];
		endcase
		drv = !f_oe_n && !f_ce_n;
	end
	always @(posedge f_oe_n) drv = 1'b0;
	// released bus never shows the last value
	assign f_dq_i = drv ? rdat : ~rdat;
endmodule
`default_nettype wire

// >>> verification/spcd_host_properties.sv
// Purpose: port properties of the protection host controller
// Assumes: bound to spcd_host from the bench top, one clock domain
// Notes:   bus figures follow the controller's 34-clock cycle walk
`timescale 1ns/100ps
`default_nettype none
module spcd_host_properties (
	// clock and reset
	input wire logic                        clk,
	input wire logic                        rst,
	// user side
	input wire logic                        cmd_valid,
	input wire logic                        cmd_ready,
	input wire spcd_pkg::spcd_op_t          cmd_op,
	input wire logic [spcd_pkg::ADDR_W-1:0] cmd_addr,
	input wire logic [spcd_pkg::DATA_W-1:0] cmd_data,
	input wire logic                        rsp_valid,
	input wire logic                        rsp_err,
	input wire logic [2:0]                  pwd_next,
	// flash pins
	input wire logic [spcd_pkg::ADDR_W-1:0] f_addr,
	input wire logic [spcd_pkg::DATA_W-1:0] f_dq_o,
	input wire logic                        f_dq_oe,
	input wire logic                        f_ce_n,
	input wire logic                        f_we_n,
	input wire logic                        f_oe_n
);
	// ==========================================================
	// helpers
	logic take;
	assign take = cmd_valid && cmd_ready;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ==========================================================
	// properties
	idle_bus_quiet_a: assert property (
		cmd_ready |-> f_ce_n && f_we_n && f_oe_n) else $error("bus strobe active while idle");
	read_no_drive_a: assert property (
		!f_oe_n |-> f_we_n && !f_dq_oe && !f_ce_n) else $error("read strobe with write or driven dq");
	write_drives_dq_a: assert property (
		!f_we_n |-> f_dq_oe && !f_ce_n) else $error("write strobe without driven dq");
	cycle_hold_a: assert property (
		!f_ce_n && $past(!f_ce_n) |-> $stable(f_addr) && $stable(f_dq_o)) else $error("address or data moved in cycle");
	we_width_a: assert property (
		$fell(f_we_n) |-> ##24 !f_we_n ##1 f_we_n) else $error("write strobe width wrong");
	lock_refuse_a: assert property (
		take && cmd_op == spcd_pkg::OP_LOCK_PROG && cmd_data[2:1] == 2'b00 |=> rsp_valid && rsp_err)
		else $error("double mode lock not refused");
	pwd_order_a: assert property (
		take && cmd_op == spcd_pkg::OP_PWD_PROG && {1'b0, cmd_addr[1:0]} != pwd_next |=> rsp_valid && rsp_err)
		else $error("out of order password word not refused");
	pwd_accept_a: assert property (
		take && cmd_op == spcd_pkg::OP_PWD_PROG && {1'b0, cmd_addr[1:0]} == pwd_next |=> !rsp_valid && !cmd_ready)
		else $error("in order password word refused");
	pwd_bound_a: assert property (
		pwd_next <= 3'h4) else $error("password index beyond four");
	read_answer_a: assert property (
		take && cmd_op == spcd_pkg::OP_ARRAY_RD |-> ##36 rsp_valid) else $error("array read answer late");
	reset_write_a: assert property (
		take && cmd_op == spcd_pkg::OP_RESET |-> ##[1:8] ($fell(f_we_n) && f_dq_o[7:0] == 8'hF0))
		else $error("reset command not written");
	rsp_pulse_a: assert property (
		rsp_valid |=> !rsp_valid) else $error("response longer than one clock");
endmodule
`default_nettype wire

// >>> verification/spcd_host_tb_top.sv
// Purpose: self-checking bench of the protection host controller
// Assumes: one operation in flight; model answers slowly
// Notes:   expectations queued by the driver, checked on each response
`timescale 1ns/100ps
`default_nettype none
module spcd_host_tb_top;
	localparam int          LIMIT = 30000;
	localparam logic [16:0] NC    = 17'h10000;
	typedef struct packed {logic e; logic [4:0] n; logic [16:0] x;} spcd_exp_t;
	logic        clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
	logic        cmd_ready, rsp_valid, rsp_protected, rsp_err, f_dq_oe, f_ce_n, f_we_n, f_oe_n;
	logic [25:0] cmd_addr = '0, sa, f_addr;
	logic [15:0] cmd_data = '0, r = 16'h0004, rsp_data, f_dq_o, f_dq_i;
	logic [63:0] cmd_pwd = '0;
	logic [2:0]  pwd_next;
	spcd_pkg::spcd_op_t cmd_op = spcd_pkg::OP_ARRAY_RD;
	spcd_exp_t   q[$];
	spcd_exp_t   ex;
	int          error_cnt = 0, n_compared = 0, cyc = 0, ncyc = 0, k;

	always #2 clk = ~clk;

	spcd_host dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_pwd(cmd_pwd), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_protected(rsp_protected), .rsp_err(rsp_err), .pwd_next(pwd_next), .f_addr(f_addr), .f_dq_o(f_dq_o),
		.f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i), .f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n));
	spcd_flash_model #(.T_ACC(90)) u_flash (.f_addr(f_addr), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe),
		.f_ce_n(f_ce_n), .f_we_n(f_we_n), .f_oe_n(f_oe_n), .f_dq_i(f_dq_i));

	// ==========================================================
	// helpers
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic wait_idle();
		while (q.size() != 0) @(posedge clk);
	endtask
	// zero bus cycles means a refusal is expected
	task automatic op(input spcd_pkg::spcd_op_t o, input logic [25:0] a, input logic [15:0] d,
			input logic [4:0] n, input logic [16:0] x);
		wait_idle();
		@(posedge clk);
		#1;
		cmd_valid = 1'b1;
		cmd_op = o;
		cmd_addr = a;
		cmd_data = d;
		q.push_back('{n == 5'h00, n, x});
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
	endtask

	// ==========================================================
	// response watcher and timeout
	always @(negedge f_ce_n) ncyc++;
	always @(posedge clk) if (!rst && rsp_valid) begin
		if (q.size() == 0) chk("unexpected response", 16'h0001, 16'h0000);
		else begin
			ex = q.pop_front();
			chk("bus cycles", 16'(ncyc), {11'h000, ex.n});
			chk("rsp_err", {15'h0000, rsp_err}, {15'h0000, ex.e});
			if (!ex.x[16]) chk("rsp_data", rsp_data, ex.x[15:0]);
			if (!ex.x[16]) chk("rsp_protected", {15'h0000, rsp_protected}, {15'h0000, ex.x[7:0] == 8'h00});
		end
		ncyc = 0;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			give_verdict();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		for (k = 0; k < 4; k++) begin
			r = lfsr(r);
			cmd_pwd[16*k +: 16] = r;
		end
		repeat (5) @(posedge clk);
		#1;
		rst = 1'b0;
		for (k = 0; k < 3; k++) begin
			r = lfsr(r);
			sa = {r[9:0], r};
			op(spcd_pkg::OP_ARRAY_RD, sa, r, 5'h01, {1'b0, sa[15:0] ^ 16'hA5C3});
		end
		sa = {10'h2B3, 16'h0000};
		op(spcd_pkg::OP_DYB_RD, sa | 26'h00000F0, r, 5'h06, 17'h00001);
		op(spcd_pkg::OP_DYB_SET, sa | 26'h000ABCD, r, 5'h07, NC);
		op(spcd_pkg::OP_DYB_RD, sa | 26'h000FFFF, r, 5'h06, 17'h00000);
		op(spcd_pkg::OP_ARRAY_RD, sa, r, 5'h01, {1'b0, sa[15:0] ^ 16'hA5C3});
		op(spcd_pkg::OP_DYB_CLR, sa, r, 5'h07, NC);
		op(spcd_pkg::OP_DYB_RD, sa, r, 5'h06, 17'h00001);
		op(spcd_pkg::OP_PPB_RD, sa, r, 5'h05, 17'h00001);
		op(spcd_pkg::OP_PPB_PROG, sa | 26'h0001234, r, 5'h07, NC);
		op(spcd_pkg::OP_PPB_RD, sa, r, 5'h05, 17'h00000);
		op(spcd_pkg::OP_PPB_RD, sa ^ 26'h0010000, r, 5'h05, 17'h00001);
		op(spcd_pkg::OP_FRZ_RD, sa, r, 5'h06, 17'h00001);
		op(spcd_pkg::OP_FRZ_CLR, sa, r, 5'h07, NC);
		op(spcd_pkg::OP_FRZ_RD, sa, r, 5'h06, 17'h00000);
		op(spcd_pkg::OP_ECC_RD, sa, r, 5'h05, 17'h00002);
		op(spcd_pkg::OP_LOCK_PROG, sa, 16'hFFF9, 5'h00, NC);
		op(spcd_pkg::OP_LOCK_PROG, sa, 16'hFFFD, 5'h07, NC);
		op(spcd_pkg::OP_PWD_PROG, 26'h0000001, r, 5'h00, NC);
		for (k = 0; k < 4; k++) op(spcd_pkg::OP_PWD_PROG, 26'(k), cmd_pwd[16*k +: 16], 5'h07, NC);
		op(spcd_pkg::OP_PWD_PROG, 26'h0000000, r, 5'h00, NC);
		op(spcd_pkg::OP_PWD_UNLK, sa, r, 5'h0C, NC);
		wait_idle();
		chk("lock register", u_flash.lock_reg, 16'hFFFD);
		chk("pwd_next", {13'h0000, pwd_next}, 16'h0004);
		chk("unlocked", {15'h0000, u_flash.unlocked}, 16'h0001);
		op(spcd_pkg::OP_RESET, sa, r, 5'h01, NC);
		op(spcd_pkg::OP_ARRAY_RD, sa, r, 5'h01, {1'b0, sa[15:0] ^ 16'hA5C3});
		wait_idle();
		give_verdict();
	end
endmodule

bind spcd_host spcd_host_properties u_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_err(rsp_err),
	.pwd_next(pwd_next), .f_addr(f_addr), .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n),
	.f_we_n(f_we_n), .f_oe_n(f_oe_n));
`default_nettype wire

// >>> verilog/spcd_bus_cycle.sv
// Purpose: one asynchronous bus cycle (write or read) on the flash pins
// Assumes: go is a one-cycle pulse accepted only while idle
// Notes:   read data captured at the end of the strobe, held in a register
`timescale 1ns/100ps
`default_nettype none
module spcd_bus_cycle (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst,
	// request
	input  wire logic                       go,
	input  wire logic                       rd,
	input  wire logic [spcd_pkg::ADDR_W-1:0] addr,
	input  wire logic [spcd_pkg::DATA_W-1:0] wdata,
	output logic                            done,
	output logic      [spcd_pkg::DATA_W-1:0] rdata,
	// flash pins
	output logic      [spcd_pkg::ADDR_W-1:0] f_addr,
	output logic      [spcd_pkg::DATA_W-1:0] f_dq_o,
	output logic                            f_dq_oe,
	input  wire logic [spcd_pkg::DATA_W-1:0] f_dq_i,
	output logic                            f_ce_n,
	output logic                            f_we_n,
	output logic                            f_oe_n
);
	typedef enum logic [1:0] {
		BC_IDLE   = 2'b00,
		BC_SETUP  = 2'b01,
		BC_STROBE = 2'b10,
		BC_HOLD   = 2'b11
	} spcd_bc_st_t;

	typedef struct packed {
		spcd_bc_st_t                 st;
		logic [7:0]                  cnt;
		logic                        rd;
		logic                        done;
		logic [spcd_pkg::ADDR_W-1:0] addr;
		logic [spcd_pkg::DATA_W-1:0] wdata;
		logic [spcd_pkg::DATA_W-1:0] rdata;
	} spcd_bc_t;

	spcd_bc_t s_r;
	spcd_bc_t s_nxt;

	always_comb begin
		s_nxt      = s_r;
		s_nxt.done = 1'b0;
		s_nxt.cnt  = s_r.cnt - 8'h01;
		case (s_r.st)
			BC_IDLE: begin
				s_nxt.cnt = spcd_pkg::C_SETUP;
				if (go) begin
					s_nxt.st    = BC_SETUP;
					s_nxt.rd    = rd;
					s_nxt.addr  = addr;
					s_nxt.wdata = wdata;
				end
			end
			BC_SETUP: begin
				if (s_r.cnt == 8'h01) begin
					s_nxt.st  = BC_STROBE;
					s_nxt.cnt = spcd_pkg::C_STROBE;
				end
			end
			BC_STROBE: begin
				if (s_r.cnt == 8'h01) begin
					s_nxt.st  = BC_HOLD;
					s_nxt.cnt = spcd_pkg::C_HOLD;
					if (s_r.rd) begin
						s_nxt.rdata = f_dq_i;
					end
				end
			end
			BC_HOLD: begin
				if (s_r.cnt == 8'h01) begin
					s_nxt.st   = BC_IDLE;
					s_nxt.done = 1'b1;
				end
			end
			default: s_nxt.st = BC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// chip enable spans the whole cycle so the strobe edge alone delimits it
	assign f_ce_n  = (s_r.st == BC_IDLE);
	assign f_we_n  = !((s_r.st == BC_STROBE) && !s_r.rd);
	assign f_oe_n  = !((s_r.st == BC_STROBE) && s_r.rd);
	assign f_dq_oe = (s_r.st != BC_IDLE) && !s_r.rd;
	assign f_addr  = s_r.addr;
	assign f_dq_o  = s_r.wdata;
	assign done    = s_r.done;
	assign rdata   = s_r.rdata;
endmodule
`default_nettype wire

// >>> verilog/spcd_host.sv
// Purpose: host controller issuing sector protection command sequences to a NOR flash
// Assumes: one operation at a time; device follows its own decoding rules
// Notes:   every overlay operation is entry, action, exit in one go
// Operation
// - command cycles are writes; only the listed reads are bus reads
// - host issues reset to leave identification mode or timeout status
// - overlay kept until exit sequence; exit returns to array read
// - host programs one password word per command, ascending order
// - unlock valid only once all four password words supplied
// - dynamic overlay entry AA/55/E0; A0 then 0 sets, A0 then 1 clears
// - persistent overlay: read at sector gives status; exit 90/0 or F0
// - freeze overlay entry ends in 50; A0 then 0 clears; read gives state
// - protection overlays exit 90 then 0; error overlay 75 entry, F0 exit
`timescale 1ns/100ps
`default_nettype none
module spcd_host (
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// user command
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire spcd_pkg::spcd_op_t          cmd_op,
	input  wire logic [spcd_pkg::ADDR_W-1:0] cmd_addr,
	input  wire logic [spcd_pkg::DATA_W-1:0] cmd_data,
	input  wire logic [spcd_pkg::PWD_W-1:0]  cmd_pwd,
	// user response
	output logic                             rsp_valid,
	output logic      [spcd_pkg::DATA_W-1:0] rsp_data,
	output logic                             rsp_protected,
	output logic                             rsp_err,
	output logic      [2:0]                  pwd_next,
	// flash pins
	output logic      [spcd_pkg::ADDR_W-1:0] f_addr,
	output logic      [spcd_pkg::DATA_W-1:0] f_dq_o,
	output logic                             f_dq_oe,
	input  wire logic [spcd_pkg::DATA_W-1:0] f_dq_i,
	output logic                             f_ce_n,
	output logic                             f_we_n,
	output logic                             f_oe_n
);
	typedef enum logic [1:0] {
		HS_IDLE  = 2'b00,
		HS_ISSUE = 2'b01,
		HS_WAIT  = 2'b10
	} spcd_hs_st_t;

	typedef struct packed {
		spcd_hs_st_t                 st;
		logic [3:0]                  idx;
		spcd_pkg::spcd_op_t          op;
		logic [spcd_pkg::ADDR_W-1:0] addr;
		logic [spcd_pkg::DATA_W-1:0] data;
		logic [spcd_pkg::PWD_W-1:0]  pwd;
		logic [2:0]                  pwd_next;
		logic                        rsp_valid;
		logic [spcd_pkg::DATA_W-1:0] rsp_data;
		logic                        rsp_prot;
		logic                        rsp_err;
	} spcd_hs_t;

	spcd_hs_t s_r;
	spcd_hs_t s_nxt;

	logic                        stp_rd;
	logic                        stp_last;
	logic [spcd_pkg::ADDR_W-1:0] stp_addr;
	logic [spcd_pkg::DATA_W-1:0] stp_data;
	logic                        bc_done;
	logic [spcd_pkg::DATA_W-1:0] bc_rdata;

	// =========================================================
	// step decode: the bus cycle for step idx of the current operation
	always_comb begin
		logic [3:0]                  j;
		logic [spcd_pkg::ADDR_W-1:0] sect;
		logic [spcd_pkg::DATA_W-1:0] entry;
		logic [spcd_pkg::DATA_W-1:0] act;
		logic [spcd_pkg::ADDR_W-1:0] act_a;
		logic [1:0]                  w;
		j        = s_r.idx - spcd_pkg::N_UNLOCK;
		sect     = s_r.addr & spcd_pkg::SECT_MASK;
		entry    = spcd_pkg::CD_DYB;
		act      = spcd_pkg::CD_ZERO;
		act_a    = sect;
		w        = 2'(j - 4'h2);
		stp_rd   = 1'b0;
		stp_last = 1'b0;
		stp_addr = spcd_pkg::ZERO_A;
		stp_data = spcd_pkg::CD_ZERO;
		case (s_r.op)
			spcd_pkg::OP_PPB_PROG, spcd_pkg::OP_PPB_RD: entry = spcd_pkg::CD_PPB;
			spcd_pkg::OP_FRZ_CLR, spcd_pkg::OP_FRZ_RD:  entry = spcd_pkg::CD_FRZ;
			spcd_pkg::OP_ECC_RD:                        entry = spcd_pkg::CD_ECC;
			spcd_pkg::OP_PWD_PROG, spcd_pkg::OP_PWD_UNLK: entry = spcd_pkg::CD_PWD;
			spcd_pkg::OP_LOCK_PROG:                     entry = spcd_pkg::CD_LOCK;
			default:                                    entry = spcd_pkg::CD_DYB;
		endcase
		case (s_r.op)
			spcd_pkg::OP_DYB_CLR: act = spcd_pkg::CD_ONE;
			spcd_pkg::OP_FRZ_CLR: act_a = spcd_pkg::ZERO_A;
			spcd_pkg::OP_LOCK_PROG: begin
				act   = s_r.data;
				act_a = spcd_pkg::ZERO_A;
			end
			spcd_pkg::OP_PWD_PROG: begin
				act   = s_r.data;
				act_a = {{(spcd_pkg::ADDR_W-2){1'b0}}, s_r.addr[1:0]};
			end
			default: act = spcd_pkg::CD_ZERO;
		endcase
		if (s_r.op == spcd_pkg::OP_ARRAY_RD) begin
			stp_rd   = 1'b1;
			stp_addr = s_r.addr;
			stp_last = 1'b1;
		end else if (s_r.op == spcd_pkg::OP_RESET) begin
			stp_data = spcd_pkg::CD_RESET;
			stp_last = 1'b1;
		end else if (s_r.idx == 4'h0) begin
			stp_addr = spcd_pkg::UNLOCK_A1;
			stp_data = spcd_pkg::CD_AA;
		end else if (s_r.idx == 4'h1) begin
			stp_addr = spcd_pkg::UNLOCK_A2;
			stp_data = spcd_pkg::CD_55;
		end else if (s_r.idx == 4'h2) begin
			stp_addr = spcd_pkg::UNLOCK_A1;
			stp_data = entry;
		end else begin
			case (s_r.op)
				spcd_pkg::OP_DYB_RD, spcd_pkg::OP_FRZ_RD, spcd_pkg::OP_PPB_RD, spcd_pkg::OP_ECC_RD: begin
					case (j)
						4'h0: begin
							stp_rd   = 1'b1;
							stp_addr = (s_r.op == spcd_pkg::OP_ECC_RD) ? s_r.addr :
								(s_r.op == spcd_pkg::OP_FRZ_RD) ? spcd_pkg::ZERO_A : sect;
						end
						4'h1: begin
							if (s_r.op == spcd_pkg::OP_ECC_RD || s_r.op == spcd_pkg::OP_PPB_RD) begin
								stp_data = spcd_pkg::CD_RESET;
								stp_last = 1'b1;
							end else begin
								stp_data = spcd_pkg::CD_EXIT1;
							end
						end
						default: stp_last = 1'b1;
					endcase
				end
				spcd_pkg::OP_PWD_UNLK: begin
					case (j)
						4'h0: stp_data = spcd_pkg::CD_UNLK1;
						4'h1: stp_data = spcd_pkg::CD_UNLK2;
						4'h2, 4'h3, 4'h4, 4'h5: begin
							stp_addr = {{(spcd_pkg::ADDR_W-2){1'b0}}, w};
							stp_data = s_r.pwd[w*spcd_pkg::DATA_W +: spcd_pkg::DATA_W];
						end
						4'h6: stp_data = spcd_pkg::CD_UNLK3;
						4'h7: stp_data = spcd_pkg::CD_EXIT1;
						default: stp_last = 1'b1;
					endcase
				end
				default: begin
					case (j)
						4'h0: stp_data = spcd_pkg::CD_PROG;
						4'h1: begin
							stp_addr = act_a;
							stp_data = act;
						end
						4'h2: stp_data = spcd_pkg::CD_EXIT1;
						default: stp_last = 1'b1;
					endcase
				end
			endcase
		end
	end

	// =========================================================
	// sequencer
	always_comb begin
		s_nxt           = s_r;
		s_nxt.rsp_valid = 1'b0;
		case (s_r.st)
			HS_IDLE: begin
				if (cmd_valid) begin
					s_nxt.op      = cmd_op;
					s_nxt.addr    = cmd_addr;
					s_nxt.data    = cmd_data;
					s_nxt.pwd     = cmd_pwd;
					s_nxt.idx     = 4'h0;
					s_nxt.rsp_err = 1'b0;
					s_nxt.st      = HS_ISSUE;
					// both mode lock bits at once would abort in the device
					if (cmd_op == spcd_pkg::OP_LOCK_PROG && !cmd_data[spcd_pkg::LK_PERSIST] &&
						!cmd_data[spcd_pkg::LK_PASSWD]) begin
						s_nxt.st        = HS_IDLE;
						s_nxt.rsp_err   = 1'b1;
						s_nxt.rsp_valid = 1'b1;
					end
					if (cmd_op == spcd_pkg::OP_PWD_PROG &&
						({1'b0, cmd_addr[1:0]} != s_r.pwd_next || s_r.pwd_next == spcd_pkg::PWD_WORDS)) begin
						s_nxt.st        = HS_IDLE;
						s_nxt.rsp_err   = 1'b1;
						s_nxt.rsp_valid = 1'b1;
					end
				end
			end
			HS_ISSUE: s_nxt.st = HS_WAIT;
			HS_WAIT: begin
				if (bc_done) begin
					if (stp_rd) begin
						s_nxt.rsp_data = bc_rdata;
						s_nxt.rsp_prot = (bc_rdata[spcd_pkg::CMD_BYTE-1:0] == spcd_pkg::ST_PROT);
					end
					if (stp_last) begin
						s_nxt.st        = HS_IDLE;
						s_nxt.rsp_valid = 1'b1;
						if (s_r.op == spcd_pkg::OP_PWD_PROG) begin
							s_nxt.pwd_next = s_r.pwd_next + 3'h1;
						end
					end else begin
						s_nxt.idx = s_r.idx + 4'h1;
						s_nxt.st  = HS_ISSUE;
					end
				end
			end
			default: s_nxt.st = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	spcd_bus_cycle u_cycle (
		.clk     (clk),
		.rst     (rst),
		.go      (s_r.st == HS_ISSUE),
		.rd      (stp_rd),
		.addr    (stp_addr),
		.wdata   (stp_data),
		.done    (bc_done),
		.rdata   (bc_rdata),
		.f_addr  (f_addr),
		.f_dq_o  (f_dq_o),
		.f_dq_oe (f_dq_oe),
		.f_dq_i  (f_dq_i),
		.f_ce_n  (f_ce_n),
		.f_we_n  (f_we_n),
		.f_oe_n  (f_oe_n)
	);

	assign cmd_ready     = (s_r.st == HS_IDLE);
	assign rsp_valid     = s_r.rsp_valid;
	assign rsp_data      = s_r.rsp_data;
	assign rsp_protected = s_r.rsp_prot;
	assign rsp_err       = s_r.rsp_err;
	assign pwd_next      = s_r.pwd_next;
endmodule
`default_nettype wire

// >>> verilog/spcd_pkg.sv
// Purpose: constants and types shared by the protection command host controller
// Assumes: x16 parallel NOR flash, 26 word-address bits, 250 MHz controller clock
// Notes:   bus timing figures are plain defaults, adjust to the fitted part
`default_nettype none
package spcd_pkg;
	// =========================================================
	// widths
	localparam int ADDR_W   = 26;
	localparam int DATA_W   = 16;
	localparam int CMD_BYTE = 8;
	localparam int SECT_LSB = 16;
	localparam int PWD_W    = 64;

	// =========================================================
	// command addresses and codes
	localparam logic [ADDR_W-1:0] UNLOCK_A1 = 26'h0000555;
	localparam logic [ADDR_W-1:0] UNLOCK_A2 = 26'h00002AA;
	localparam logic [ADDR_W-1:0] ZERO_A    = 26'h0000000;
	localparam logic [ADDR_W-1:0] SECT_MASK = 26'h3FF0000;
	localparam logic [DATA_W-1:0] CD_AA     = 16'h00AA;
	localparam logic [DATA_W-1:0] CD_55     = 16'h0055;
	localparam logic [DATA_W-1:0] CD_DYB    = 16'h00E0;
	localparam logic [DATA_W-1:0] CD_PPB    = 16'h00C0;
	localparam logic [DATA_W-1:0] CD_FRZ    = 16'h0050;
	localparam logic [DATA_W-1:0] CD_ECC    = 16'h0075;
	localparam logic [DATA_W-1:0] CD_PWD    = 16'h0060;
	localparam logic [DATA_W-1:0] CD_LOCK   = 16'h0040;
	localparam logic [DATA_W-1:0] CD_PROG   = 16'h00A0;
	localparam logic [DATA_W-1:0] CD_EXIT1  = 16'h0090;
	localparam logic [DATA_W-1:0] CD_ZERO   = 16'h0000;
	localparam logic [DATA_W-1:0] CD_ONE    = 16'h0001;
	localparam logic [DATA_W-1:0] CD_RESET  = 16'h00F0;
	localparam logic [DATA_W-1:0] CD_UNLK1  = 16'h0025;
	localparam logic [DATA_W-1:0] CD_UNLK2  = 16'h0003;
	localparam logic [DATA_W-1:0] CD_UNLK3  = 16'h0029;
	localparam logic [7:0]        ST_PROT   = 8'h00;

	// lock register: positions of the two mode lock bits
	localparam int LK_PERSIST = 1;
	localparam int LK_PASSWD  = 2;

	// =========================================================
	// sequence steps
	localparam logic [3:0] N_UNLOCK  = 4'h3;
	localparam logic [2:0] PWD_WORDS = 3'h4;

	// =========================================================
	// bus timing
	localparam int CLK_PS      = 4000;
	localparam int T_SETUP_NS  = 10;
	localparam int T_STROBE_NS = 100;
	localparam int T_HOLD_NS   = 20;
	localparam logic [7:0] C_SETUP  = 8'((T_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] C_STROBE = 8'((T_STROBE_NS * 1000 + CLK_PS - 1) / CLK_PS);
	localparam logic [7:0] C_HOLD   = 8'((T_HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS);

	// =========================================================
	// user operations
	typedef enum logic [3:0] {
		OP_ARRAY_RD  = 4'b0000,
		OP_RESET     = 4'b0001,
		OP_DYB_SET   = 4'b0010,
		OP_DYB_CLR   = 4'b0011,
		OP_DYB_RD    = 4'b0100,
		OP_PPB_PROG  = 4'b0101,
		OP_PPB_RD    = 4'b0110,
		OP_FRZ_CLR   = 4'b0111,
		OP_FRZ_RD    = 4'b1000,
		OP_ECC_RD    = 4'b1001,
		OP_PWD_PROG  = 4'b1010,
		OP_PWD_UNLK  = 4'b1011,
		OP_LOCK_PROG = 4'b1100
	} spcd_op_t;
endpackage
`default_nettype wire
